// File: psc_pkg.sv
// constants and types of the power state controller
package psc_pkg;

  // =====================================================
  // operating states
  typedef enum logic [2:0]
  {
    PSC_ZERO    = 3'b000,
    PSC_BACKUP  = 3'b001,
    PSC_OFF     = 3'b010,
    PSC_PREACT  = 3'b011,
    PSC_ACTIVE  = 3'b100,
    PSC_HIBER   = 3'b101
  } psc_state_type;

  // =====================================================
  // configuration modes taken from the straps
  localparam logic [1:0] PSC_MODE_DEV = 2'h0;

  // fixed start-up parameter words of the three custom modes
  localparam logic [15:0] PSC_CUSTOM1_PARAM = 16'h1111;
  localparam logic [15:0] PSC_CUSTOM2_PARAM = 16'h2222;
  localparam logic [15:0] PSC_CUSTOM3_PARAM = 16'h3333;

  // =====================================================
  // register indices; byte address is four times the index
  localparam logic [9:0] PSC_IDX_SLEEP = 10'h005;
  localparam logic [9:0] PSC_IDX_HIB_SUPPLY = 10'h040;
  localparam logic [9:0] PSC_IDX_STARTUP = 10'h041;
  localparam logic [9:0] PSC_IDX_OFF_CFG = 10'h042;
  localparam logic [9:0] PSC_IDX_STATUS = 10'h043;

  // field positions
  localparam int PSC_HIB_BIT = 15;
  localparam int PSC_GO_BIT = 16;
  localparam int PSC_KEEP_LINREG1_BIT = 0;
  localparam int PSC_OFF_TRICKLE_BIT = 1;

  // values after reset
  localparam logic [9:0] PSC_HIB_SUPPLY_RST = 10'h000;
  localparam logic [15:0] PSC_STARTUP_RST = 16'h0000;
  localparam logic PSC_KEEP_LINREG1_RST = 1'b0;
  localparam logic PSC_OFF_TRICKLE_RST = 1'b1;

  localparam int PSC_N_CONV = 6;
  localparam int PSC_N_LINREG = 4;

endpackage : psc_pkg

// File: psc_power_state_controller.sv
// operating-state controller with its apb register file
//
// How it works
// RQ1 - start-up fault sends device to off
// RQ2 - active reached via pre-active after sequence completes
// RQ3 - active has no entry but pre-active; the code also enters active from hibernate
// RQ4 - development mode: parameters writable in pre-active
// RQ5 - four strap modes: development plus three custom
// RQ6 - hibernate bit or gpio enters hibernate
// RQ7 - gpio edge or level may enter hibernate
// RQ8 - level release, edge or wake leaves hibernate
// RQ9 - fault in hibernate goes to off
// RQ10 - hibernate bit 15 at 05h, reset zero
// RQ11 - hibernate supplies individually programmable
// RQ12 - hibernate blocks fast charge, allows trickle
// RQ13 - off disables converters and regulators two-four
// RQ14 - entering off restores register defaults
// RQ15 - off enables trickle charging by default
// RQ16 - shutdown or low source: active to off
// RQ17 - off to backup on lockout, backup rail good
// RQ18 - backup runs only oscillator and clock
// RQ19 - backup returns to off when source returns
// RQ20 - no source, rail below reset: zero
// RQ21 - start-up key held over 40ms
// RQ22 - start-up only above start-up voltage threshold
// RQ23 - undefined transitions ignored, state holds
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module psc_power_state_controller
  import psc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps
  input wire logic [1:0] config_mode_strap,
  // supply conditions
  input wire logic line_above_lockout_level,
  input wire logic backup_supply_rail_ok,
  input wire logic line_above_startup_voltage_threshold,
  // events
  input wire logic startup_event,
  input wire logic shutdown_event,
  input wire logic below_shutdown_threshold,
  input wire logic fault,
  input wire logic startup_seq_done,
  input wire logic gpio_hib_edge,
  input wire logic gpio_hib_level,
  input wire logic wake_event,
  // power outputs
  output logic [PSC_N_CONV-1:0] conv_en,
  output logic [PSC_N_LINREG-1:0] linreg_en,
  output logic osc_rtc_en,
  output logic fast_charge_en,
  output logic trickle_charge_en,
  output logic restore_defaults,
  output logic startup_seq_run,
  output logic [15:0] startup_param,
  output psc_pkg::psc_state_type state
);
  import psc_pkg::*;

  // =====================================================
  // state
  typedef struct packed
  {
    psc_state_type st;
    logic [1:0] mode;
    logic strap_taken;
    logic hib_bit;
    logic hib_by_level;
    logic [9:0] hib_supply;
    logic [15:0] dev_param;
    logic go;
    logic keep_linreg1;
    logic off_trickle;
    logic [31:0] rdata;
    logic err;
    logic [PSC_N_CONV-1:0] conv;
    logic [PSC_N_LINREG-1:0] linreg;
    logic osc;
    logic fast;
    logic trickle;
    logic restore;
    logic seq_run;
  } psc_regs_type;

  psc_regs_type r;
  psc_regs_type next_r;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[1:0] == 2'h0) && (a[11:2] == idx);
  endfunction : hit

  function automatic logic [15:0] param_of(input logic [1:0] m, input logic [15:0] dev);
    case (m)
      2'h1: param_of = PSC_CUSTOM1_PARAM;
      2'h2: param_of = PSC_CUSTOM2_PARAM;
      2'h3: param_of = PSC_CUSTOM3_PARAM;
      default: param_of = dev;
    endcase
  endfunction : param_of

  logic setup;
  logic wr;
  logic zero_cond;
  logic mapped;
  logic param_open;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign zero_cond = !line_above_lockout_level && !backup_supply_rail_ok;
  assign mapped = hit(paddr, PSC_IDX_SLEEP) || hit(paddr, PSC_IDX_HIB_SUPPLY) ||
    hit(paddr, PSC_IDX_STARTUP) || hit(paddr, PSC_IDX_OFF_CFG) || hit(paddr, PSC_IDX_STATUS);
  assign param_open = (r.mode == PSC_MODE_DEV) && (r.st == PSC_PREACT) && !r.go;

  // =====================================================
  // next state
  always_comb
  begin
    next_r = r;
    next_r.restore = 1'b0;
    // straps are caught once after reset release
    if (!r.strap_taken)
    begin
      next_r.mode = config_mode_strap; // RQ5
      next_r.strap_taken = 1'b1;
    end
    // register writes
    if (wr && hit(paddr, PSC_IDX_SLEEP))
    begin
      next_r.hib_bit = pwdata[PSC_HIB_BIT]; // RQ10
    end
    if (wr && hit(paddr, PSC_IDX_HIB_SUPPLY))
    begin
      next_r.hib_supply = pwdata[9:0]; // RQ11
    end
    if (wr && hit(paddr, PSC_IDX_STARTUP) && param_open)
    begin
      next_r.dev_param = pwdata[15:0]; // RQ4
      next_r.go = pwdata[PSC_GO_BIT];
    end
    if (wr && hit(paddr, PSC_IDX_OFF_CFG))
    begin
      next_r.keep_linreg1 = pwdata[PSC_KEEP_LINREG1_BIT];
      next_r.off_trickle = pwdata[PSC_OFF_TRICKLE_BIT];
    end
    // read data and error are taken in the setup cycle
    if (setup)
    begin
      next_r.err = !mapped;
      next_r.rdata = 32'h0000_0000;
      if (hit(paddr, PSC_IDX_SLEEP))
        next_r.rdata[PSC_HIB_BIT] = r.hib_bit;
      if (hit(paddr, PSC_IDX_HIB_SUPPLY))
        next_r.rdata[9:0] = r.hib_supply;
      if (hit(paddr, PSC_IDX_STARTUP))
        next_r.rdata = {15'h0000, r.go, param_of(r.mode, r.dev_param)};
      if (hit(paddr, PSC_IDX_OFF_CFG))
        next_r.rdata[1:0] = {r.off_trickle, r.keep_linreg1};
      if (hit(paddr, PSC_IDX_STATUS))
        next_r.rdata[7:0] = {r.seq_run, r.mode, r.hib_by_level, 1'b0, r.st};
    end
    // transitions; anything not listed holds the state
    if (zero_cond)
    begin
      next_r.st = PSC_ZERO; // RQ20
    end
    else
    begin
      case (r.st)
        PSC_ZERO:
          if (line_above_lockout_level)
            next_r.st = PSC_OFF;
        PSC_BACKUP:
          if (line_above_lockout_level)
            next_r.st = PSC_OFF; // RQ19
        PSC_OFF:
          if (!line_above_lockout_level)
            next_r.st = PSC_BACKUP; // RQ17
          else if (startup_event && line_above_startup_voltage_threshold)
            next_r.st = PSC_PREACT; // RQ22
        PSC_PREACT:
          if (fault)
            next_r.st = PSC_OFF; // RQ1
          else if (r.seq_run && startup_seq_done)
            next_r.st = PSC_ACTIVE; // RQ2 RQ3
        PSC_ACTIVE:
          if (shutdown_event || below_shutdown_threshold)
            next_r.st = PSC_OFF; // RQ16
          else if (r.hib_bit || gpio_hib_level || gpio_hib_edge)
          begin
            next_r.st = PSC_HIBER; // RQ6
            next_r.hib_by_level = !gpio_hib_edge; // RQ7
          end
        PSC_HIBER:
          if (fault)
            next_r.st = PSC_OFF; // RQ9
          else if (gpio_hib_edge || wake_event ||
                   (r.hib_by_level && !gpio_hib_level && !r.hib_bit))
          begin
            next_r.st = PSC_ACTIVE; // RQ8
            next_r.hib_bit = 1'b0;
          end
        default:
          next_r.st = PSC_ZERO; // RQ23
      endcase
    end
    // sequence starts one cycle after pre-active entry in custom modes, one cycle after the go bit in development mode
    next_r.seq_run = (next_r.st == PSC_PREACT) && (r.st == PSC_PREACT) &&
      (r.seq_run || (r.mode != PSC_MODE_DEV) || r.go);
    // defaults return on entry to off and while in zero
    if ((next_r.st == PSC_OFF && r.st != PSC_OFF) || next_r.st == PSC_ZERO)
    begin
      next_r.restore = 1'b1; // RQ14
      next_r.hib_bit = 1'b0;
      next_r.hib_by_level = 1'b0;
      next_r.hib_supply = PSC_HIB_SUPPLY_RST;
      next_r.dev_param = PSC_STARTUP_RST;
      next_r.go = 1'b0;
      next_r.keep_linreg1 = PSC_KEEP_LINREG1_RST;
      next_r.off_trickle = PSC_OFF_TRICKLE_RST;
    end
    // outputs follow the state being entered
    next_r.conv = '0;
    next_r.linreg = '0;
    next_r.fast = 1'b0;
    next_r.trickle = 1'b0;
    next_r.osc = (next_r.st != PSC_ZERO); // RQ18
    case (next_r.st)
      PSC_OFF:
      begin
        next_r.linreg[0] = next_r.keep_linreg1; // RQ13
        next_r.trickle = next_r.off_trickle; // RQ15
      end
      PSC_PREACT:
      begin
        next_r.conv = {PSC_N_CONV{next_r.seq_run}};
        next_r.linreg = {PSC_N_LINREG{next_r.seq_run}};
      end
      PSC_ACTIVE:
      begin
        next_r.conv = '1;
        next_r.linreg = '1;
        next_r.fast = 1'b1;
        next_r.trickle = 1'b1;
      end
      PSC_HIBER:
      begin
        next_r.conv = next_r.hib_supply[PSC_N_CONV-1:0]; // RQ11
        next_r.linreg = next_r.hib_supply[9:PSC_N_CONV];
        next_r.trickle = 1'b1; // RQ12
      end
      default:
      begin
        next_r.osc = next_r.osc;
      end
    endcase
  end

  // =====================================================
  // registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= PSC_ZERO;
      r.off_trickle <= PSC_OFF_TRICKLE_RST;
      r.dev_param <= PSC_STARTUP_RST;
      r.hib_supply <= PSC_HIB_SUPPLY_RST;
      r.keep_linreg1 <= PSC_KEEP_LINREG1_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // =====================================================
  // outputs
  assign pready = 1'b1;
  assign prdata = r.rdata;
  assign pslverr = r.err;
  assign conv_en = r.conv;
  assign linreg_en = r.linreg;
  assign osc_rtc_en = r.osc;
  assign fast_charge_en = r.fast;
  assign trickle_charge_en = r.trickle;
  assign restore_defaults = r.restore;
  assign startup_seq_run = r.seq_run;
  assign startup_param = param_of(r.mode, r.dev_param);
  assign state = r.st;

  // =====================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_active_entry_path: assert property ($rose(r.st == PSC_ACTIVE) |-> // RQ3
    ($past(r.st) == PSC_PREACT && $past(r.seq_run)) || $past(r.st) == PSC_HIBER)
    else $error("active entered by an undefined path");
  a_seq_done_active: assert property (r.st == PSC_PREACT && r.seq_run && startup_seq_done && !fault && !zero_cond
    |=> r.st == PSC_ACTIVE) // RQ2
    else $error("completed start-up did not reach active");
  a_startup_fault_off: assert property (r.st == PSC_PREACT && fault && !zero_cond |=> r.st == PSC_OFF) // RQ1
    else $error("fault in start-up did not go to off");
  a_hib_fault_off: assert property (r.st == PSC_HIBER && fault && !zero_cond |=> r.st == PSC_OFF) // RQ9
    else $error("fault in hibernate did not go to off");
  a_hib_bit_entry: assert property (r.st == PSC_ACTIVE && r.hib_bit && !shutdown_event &&
    !below_shutdown_threshold && !zero_cond |=> r.st == PSC_HIBER && !fast_charge_en && trickle_charge_en) // RQ6
    else $error("hibernate bit did not enter hibernate");
  a_hib_charge: assert property (r.st == PSC_HIBER |-> !fast_charge_en && trickle_charge_en) // RQ12
    else $error("charging mode wrong in hibernate");
  a_off_rails: assert property (r.st == PSC_OFF |-> conv_en == '0 && linreg_en[3:1] == 3'h0) // RQ13
    else $error("rail enabled in off");
  a_off_restore: assert property (r.st != PSC_OFF && !zero_cond ##1 r.st == PSC_OFF
    |-> restore_defaults && !r.hib_bit && trickle_charge_en) // RQ14
    else $error("defaults not restored on entry to off");
  a_backup_entry: assert property (r.st == PSC_OFF && !line_above_lockout_level && backup_supply_rail_ok
    |=> r.st == PSC_BACKUP ##0 conv_en == '0 && linreg_en == '0 && osc_rtc_en) // RQ17
    else $error("off did not fall to backup");
  a_zero_entry: assert property (zero_cond |=> r.st == PSC_ZERO && !osc_rtc_en) // RQ20
    else $error("zero state not entered");
  a_start_threshold: assert property (r.st == PSC_OFF && !line_above_startup_voltage_threshold |=> r.st != PSC_PREACT) // RQ22
    else $error("start-up taken below threshold");
  a_param_locked: assert property (wr && hit(paddr, PSC_IDX_STARTUP) && !param_open && !zero_cond
    && !(r.st == PSC_PREACT && fault) |=> $stable(r.dev_param) || restore_defaults) // RQ4
    else $error("start-up parameters changed outside pre-active");

  c_reach_active: cover property (r.st == PSC_PREACT ##1 r.st == PSC_ACTIVE);
  c_hib_round: cover property (r.st == PSC_HIBER ##1 r.st == PSC_ACTIVE);
  c_backup_cycle: cover property (r.st == PSC_BACKUP ##1 r.st == PSC_OFF);

endmodule : psc_power_state_controller

`default_nettype wire

// File: psc_key_model.sv
// start-up key source with its hold filter, as seen by the controller
`timescale 1ns/1ns
`default_nettype none

module psc_key_model #(
  parameter int HOLD = 40
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // key level and qualified event
  input wire logic key,
  output logic startup_event
);
  int cnt;

  // ==========================================
  // one-cycle event once the key is held past the hold span
  always_ff @(posedge mclk)
  begin
    if (rst || !key)
    begin
      cnt <= 0;
      startup_event <= 1'b0;
    end
    else
    begin
      cnt <= (cnt > HOLD) ? cnt : cnt + 1;
      startup_event <= (cnt == HOLD);
    end
  end
endmodule : psc_key_model

`default_nettype wire

// File: tb_top.sv
// self-checking bench of the power state controller
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import psc_pkg::*;
  localparam logic [11:0] a_sleep = {PSC_IDX_SLEEP, 2'b00};
  localparam logic [11:0] a_hsup = {PSC_IDX_HIB_SUPPLY, 2'b00};
  localparam logic [11:0] a_start = {PSC_IDX_STARTUP, 2'b00};
  localparam logic [11:0] a_offc = {PSC_IDX_OFF_CFG, 2'b00};
  localparam logic [11:0] a_stat = {PSC_IDX_STATUS, 2'b00};
  logic [1:0] config_mode_strap = 2'h0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_above_lockout_level = 1'b0;
  logic backup_supply_rail_ok = 1'b0;
  logic line_above_startup_voltage_threshold = 1'b0;
  logic key = 1'b0;
  logic startup_event;
  logic shutdown_event = 1'b0;
  logic below_shutdown_threshold = 1'b0;
  logic fault = 1'b0;
  logic startup_seq_done = 1'b0;
  logic gpio_hib_edge = 1'b0;
  logic gpio_hib_level = 1'b0;
  logic wake_event = 1'b0;
  logic [PSC_N_CONV-1:0] conv_en;
  logic [PSC_N_LINREG-1:0] linreg_en;
  logic osc_rtc_en;
  logic fast_charge_en;
  logic trickle_charge_en;
  logic restore_defaults;
  logic startup_seq_run;
  logic [15:0] startup_param;
  psc_state_type state;
  int num_errors = 0;
  int checks_done = 0;

  // ==========================================
  // design and key source
  psc_power_state_controller i_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .config_mode_strap, .line_above_lockout_level, .backup_supply_rail_ok,
    .line_above_startup_voltage_threshold, .startup_event, .shutdown_event, .below_shutdown_threshold, .fault,
    .startup_seq_done, .gpio_hib_edge, .gpio_hib_level, .wake_event, .conv_en, .linreg_en, .osc_rtc_en,
    .fast_charge_en, .trickle_charge_en, .restore_defaults, .startup_seq_run, .startup_param, .state);
  psc_key_model #(.HOLD(40)) i_key (.mclk, .rst, .key, .startup_event);

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  // ==========================================
  // compares and bus cycles
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_st(input psc_state_type exp);
    checks_done++;
    if (state !== exp)
    begin
      num_errors++;
      $display("Error at %0t: state %0d, expected %0d", $time, state, exp);
    end
  endtask : chk_st

  task automatic wait_st(input psc_state_type s);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (state !== s && n < 80);
    chk_st(s);
  endtask : wait_st

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk_v(q, exp);
    chk_v({31'h0, e}, {31'h0, exp_err});
  endtask : rd

  task automatic go_active;
    @(posedge mclk);
    line_above_startup_voltage_threshold <= 1'b1;
    key <= 1'b1;
    wait_st(PSC_PREACT);
    key <= 1'b0;
    wr(a_start, 32'h0001ABCD);
    repeat (2) @(posedge mclk);
    #1;
    chk_v({16'h0, startup_param}, 32'h0000ABCD);
    chk_v({31'h0, startup_seq_run}, 32'h1);
    @(posedge mclk);
    startup_seq_done <= 1'b1;
    wait_st(PSC_ACTIVE);
    startup_seq_done <= 1'b0;
    chk_v({31'h0, fast_charge_en}, 32'h1);
  endtask : go_active

  // ==========================================
  // scenarios
  task automatic t_power;
    rd(a_sleep, 32'h0, 1'b0);
    rd(12'h300, 32'h0, 1'b1);
    @(posedge mclk);
    line_above_lockout_level <= 1'b1;
    backup_supply_rail_ok <= 1'b1;
    wait_st(PSC_OFF);
    chk_v({26'h0, conv_en}, 32'h0);
    chk_v({29'h0, linreg_en[3:1]}, 32'h0);
    chk_v({31'h0, trickle_charge_en}, 32'h1);
    key <= 1'b1;
    repeat (60) @(posedge mclk);
    #1;
    chk_st(PSC_OFF);
    key <= 1'b0;
    $display("test power-up done");
  endtask : t_power

  task automatic t_hib;
    go_active();
    wr(a_hsup, 32'h00000005);
    wr(a_sleep, 32'h00008000);
    wait_st(PSC_HIBER);
    chk_v({26'h0, conv_en}, 32'h5);
    chk_v({31'h0, fast_charge_en}, 32'h0);
    chk_v({31'h0, trickle_charge_en}, 32'h1);
    rd(a_sleep, 32'h00008000, 1'b0);
    wr(a_sleep, 32'h0);
    wait_st(PSC_ACTIVE);
    gpio_hib_edge <= 1'b1;
    @(posedge mclk);
    gpio_hib_edge <= 1'b0;
    wait_st(PSC_HIBER);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    wait_st(PSC_ACTIVE);
    gpio_hib_level <= 1'b1;
    wait_st(PSC_HIBER);
    gpio_hib_level <= 1'b0;
    wait_st(PSC_ACTIVE);
    $display("test hibernate done");
  endtask : t_hib

  task automatic t_off;
    wr(a_sleep, 32'h00008000);
    wait_st(PSC_HIBER);
    fault <= 1'b1;
    wait_st(PSC_OFF);
    chk_v({31'h0, restore_defaults}, 32'h1);
    fault <= 1'b0;
    rd(a_hsup, 32'h0, 1'b0);
    rd(a_sleep, 32'h0, 1'b0);
    go_active();
    shutdown_event <= 1'b1;
    wait_st(PSC_OFF);
    shutdown_event <= 1'b0;
    $display("test fault and shutdown done");
  endtask : t_off

  task automatic t_backup;
    @(posedge mclk);
    line_above_lockout_level <= 1'b0;
    wait_st(PSC_BACKUP);
    chk_v({21'h0, osc_rtc_en, conv_en, linreg_en}, 32'h400);
    chk_v({30'h0, fast_charge_en, trickle_charge_en}, 32'h0);
    line_above_lockout_level <= 1'b1;
    wait_st(PSC_OFF);
    line_above_lockout_level <= 1'b0;
    wait_st(PSC_BACKUP);
    backup_supply_rail_ok <= 1'b0;
    wait_st(PSC_ZERO);
    chk_v({31'h0, osc_rtc_en}, 32'h0);
    $display("test backup done");
  endtask : t_backup

  task automatic t_custom;
    @(posedge mclk);
    rst <= 1'b1;
    config_mode_strap <= 2'h1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    line_above_lockout_level <= 1'b1;
    backup_supply_rail_ok <= 1'b1;
    wait_st(PSC_OFF);
    key <= 1'b1;
    wait_st(PSC_PREACT);
    key <= 1'b0;
    @(posedge mclk);
    #1;
    chk_v({31'h0, startup_seq_run}, 32'h1);
    chk_v({16'h0, startup_param}, {16'h0, PSC_CUSTOM1_PARAM});
    wr(a_start, 32'h0001ABCD);
    rd(a_start, {16'h0, PSC_CUSTOM1_PARAM}, 1'b0);
    rd(a_stat, 32'h000000A3, 1'b0);
    fault <= 1'b1;
    wait_st(PSC_OFF);
    fault <= 1'b0;
    wr(a_offc, 32'h00000001);
    @(posedge mclk);
    #1;
    chk_v({27'h0, trickle_charge_en, linreg_en}, 32'h1);
    $display("test custom mode done");
  endtask : t_custom

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    chk_st(PSC_ZERO);
    t_power();
    t_hib();
    t_off();
    t_backup();
    t_custom();
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
